// ===== rtl/delay_parts.sv
// Leaf parts of the tapped delay line: an input FIFO and one tap segment memory.
// Assumes a single clock; rst_n is synchronous and active low.
`timescale 1ns/1ns
`default_nettype none
module word_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8,
  parameter int PW = 3
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic inValid,
  output logic inReady,
  input wire logic [WIDTH-1:0] inData,
  output logic outValid,
  input wire logic outReady,
  output logic [WIDTH-1:0] outData,
  output logic [PW:0] level
);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [PW-1:0] wr_q, wr_d, rd_q, rd_d;
  logic [PW:0] cnt_q, cnt_d;
  logic push, pop;

  assign inReady = (cnt_q != (PW+1)'(DEPTH));
  assign outValid = (cnt_q != '0);
  assign outData = mem[rd_q];
  assign level = cnt_q;
  assign push = inValid && inReady;
  assign pop = outValid && outReady;

  always_comb begin
    wr_d = wr_q;
    rd_d = rd_q;
    cnt_d = cnt_q;
    if (push) wr_d = (wr_q == PW'(DEPTH - 1)) ? '0 : wr_q + 1'b1;
    if (pop) rd_d = (rd_q == PW'(DEPTH - 1)) ? '0 : rd_q + 1'b1;
    if (push && !pop) cnt_d = cnt_q + 1'b1;
    else if (pop && !push) cnt_d = cnt_q - 1'b1;
    if (!rst_n) begin
      wr_d = '0;
      rd_d = '0;
      cnt_d = '0;
    end
  end

  always_ff @(posedge clk) begin
    wr_q <= wr_d;
    rd_q <= rd_d;
    cnt_q <= cnt_d;
  end

  always_ff @(posedge clk) begin
    if (push) mem[wr_q] <= inData;
  end
endmodule // word_fifo

module tap_ram #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8,
  parameter int AW = 3
) (
  input wire logic clk,
  input wire logic clr,
  input wire logic rst_n,
  input wire logic we,
  input wire logic [AW-1:0] waddr,
  input wire logic [WIDTH-1:0] wdata,
  input wire logic [AW-1:0] raddr,
  input wire logic rdMask,
  input wire logic flush,
  output logic [WIDTH-1:0] rdata
);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [WIDTH-1:0] rdata_q, rdata_d;

  // The array itself cannot be cleared at once; stale words are masked instead
  always_comb begin
    rdata_d = rdata_q;
    if (!rst_n || flush) rdata_d = '0;
    else if (we) rdata_d = rdMask ? '0 : mem[raddr];
  end

  always_ff @(posedge clk) begin
    if (we) mem[waddr] <= wdata;
  end

  always_ff @(posedge clk or posedge clr) begin
    if (clr) rdata_q <= '0;
    else rdata_q <= rdata_d;
  end

  assign rdata = rdata_q;
endmodule // tap_ram
`default_nettype wire

// ===== rtl/ram_tapped_delay_line.sv
// Memory-backed tapped delay line with an input FIFO and an AXI4-Lite control port.
// Assumes words arrive synchronous to mclk; asyncClear may arrive at any time.
// Behaviour
// - Input word and chain output are WORD_W bits, chosen from the permitted widths.
// - Chain advances one place per rising edge only while the advance enable is high.
// - Asserted clear empties the whole chain at once, without a clock edge.
// - Chain output reads zero immediately while clear is asserted.
// - Chain output shows the word at the last position, WORD_W bits wide.
// - Tap bus concatenates TAP_COUNT fields of WORD_W bits, one per tap.
// - Tap count is a permitted build choice; taps are spaced evenly.
// - Tap spacing counts clock cycles, permitted values only, never below three.
// - Each tap segment uses one memory word per cycle of spacing.
// - Clear path exists only when the clear build option is on.
// - Optional build setting also presents each tap as its own word output.
`timescale 1ns/1ns
`default_nettype none
module ram_tapped_delay_line
  import tap_delay_pkg::*;
(
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic [tap_delay_pkg::WORD_W-1:0] inWord,
  input wire logic inValid,
  output logic inReady,
  input wire logic advanceEnable,
  input wire logic asyncClear,
  output logic [tap_delay_pkg::WORD_W-1:0] chainOut,
  output logic [tap_delay_pkg::TAPS_W-1:0] tapOut,
  output logic [tap_delay_pkg::WORD_W-1:0] tapWord [tap_delay_pkg::TAP_COUNT],
  input wire logic [tap_delay_pkg::ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [tap_delay_pkg::ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  import tap_delay_pkg::*;

  function automatic regSel_t regDecode(input logic [ADDR_W-1:0] addr);
    regSel_t sel;
    sel = REG_NONE;
    case (addr)
      CTRL_OFFSET: sel = REG_CTRL;
      STATUS_OFFSET: sel = REG_STATUS;
      ADVCOUNT_OFFSET: sel = REG_ADVCOUNT;
      CHAINOUT_OFFSET: sel = REG_CHAINOUT;
      PARAMS_OFFSET: sel = REG_PARAMS;
      REFUSED_OFFSET: sel = REG_REFUSED;
      default: sel = REG_NONE;
    endcase
    return sel;
  endfunction

  function automatic logic [PTR_W-1:0] ptrNext(input logic [PTR_W-1:0] p);
    return (p == PTR_LAST) ? PTR_RESET : p + 1'b1;
  endfunction

  // Chain state
  logic clrInt;
  logic advEn;
  logic advance;
  logic flushNow;
  logic readMask;
  logic [PTR_W-1:0] ptr_q, ptr_d, rdPtr;
  logic [FILL_W-1:0] fill_q, fill_d;
  logic [31:0] advCount_q, advCount_d;
  logic [31:0] refused_q, refused_d;
  logic [WORD_W-1:0] segIn [TAP_COUNT];
  logic [WORD_W-1:0] tap [TAP_COUNT];

  // FIFO
  logic fifoValid;
  logic fifoPopReady;
  logic [WORD_W-1:0] fifoData;
  logic [FIFO_PTR_W:0] fifoLevel;

  // Register port state
  logic run_q, run_d;
  logic awHave_q, awHave_d;
  logic wHave_q, wHave_d;
  logic [ADDR_W-1:0] awAddr_q, awAddr_d;
  logic [31:0] wData_q, wData_d;
  logic [3:0] wStrb_q, wStrb_d;
  logic bValid_q, bValid_d;
  logic [1:0] bResp_q, bResp_d;
  logic rValid_q, rValid_d;
  logic [31:0] rData_q, rData_d;
  logic [1:0] rResp_q, rResp_d;
  logic doWrite;
  regSel_t wrSel;
  regSel_t rdSel;
  logic [31:0] rdWord;

  assign clrInt = HAS_CLEAR & asyncClear;
  assign advEn = HAS_ENABLE ? advanceEnable : 1'b1;
  // Back-pressure: a stalled chain stops draining, so the FIFO fills and inReady drops
  assign fifoPopReady = advEn && run_q;
  assign advance = fifoPopReady && fifoValid;
  assign rdPtr = ptrNext(ptr_q);
  // A word read at rdPtr was written SPACING-1 advances ago; before that it is stale
  assign readMask = (fill_q < READ_MIN);

  word_fifo #(
    .WIDTH(WORD_W),
    .DEPTH(FIFO_DEPTH),
    .PW(FIFO_PTR_W)
  ) uInFifo (
    .clk(mclk),
    .rst_n(rst_n),
    .inValid(inValid),
    .inReady(inReady),
    .inData(inWord),
    .outValid(fifoValid),
    .outReady(fifoPopReady),
    .outData(fifoData),
    .level(fifoLevel)
  );

  assign segIn[0] = fifoData;

  // One memory of TAP_SPACING words per segment, all on one shared pointer
  for (genvar k = 0; k < TAP_COUNT; k++) begin : gSeg
    if (k > 0) begin : gLink
      assign segIn[k] = tap[k-1];
    end
    tap_ram #(
      .WIDTH(WORD_W),
      .DEPTH(TAP_SPACING),
      .AW(PTR_W)
    ) uSeg (
      .clk(mclk),
      .clr(clrInt),
      .rst_n(rst_n),
      .we(advance),
      .waddr(ptr_q),
      .wdata(segIn[k]),
      .raddr(rdPtr),
      .rdMask(readMask),
      .flush(flushNow),
      .rdata(tap[k])
    );
    assign tapOut[k*WORD_W +: WORD_W] = tap[k];
    assign tapWord[k] = HAS_TAP_GROUPS ? tap[k] : '0;
  end

  assign chainOut = tap[TAP_COUNT-1];

  always_comb begin
    ptr_d = ptr_q;
    fill_d = fill_q;
    advCount_d = advCount_q;
    refused_d = refused_q;
    if (advance) begin
      ptr_d = rdPtr;
      advCount_d = advCount_q + 32'h0000_0001;
      if (fill_q != FILL_MAX) fill_d = fill_q + 1'b1;
    end
    if (inValid && !inReady) refused_d = refused_q + 32'h0000_0001;
    if (flushNow) begin
      fill_d = '0;
      advCount_d = COUNT_RESET;
    end
    if (!rst_n) begin
      ptr_d = PTR_RESET;
      fill_d = '0;
      advCount_d = COUNT_RESET;
      refused_d = COUNT_RESET;
    end
  end

  always_ff @(posedge mclk) begin
    ptr_q <= ptr_d;
    refused_q <= refused_d;
  end

  // Clear forgets every word at once by zeroing the fill count
  always_ff @(posedge mclk or posedge clrInt) begin
    if (clrInt) begin
      fill_q <= '0;
      advCount_q <= COUNT_RESET;
    end else begin
      fill_q <= fill_d;
      advCount_q <= advCount_d;
    end
  end

  // Write channel: address and data may arrive in either order
  assign s_axi_awready = !awHave_q && !bValid_q;
  assign s_axi_wready = !wHave_q && !bValid_q;
  assign doWrite = awHave_q && wHave_q && !bValid_q;
  assign wrSel = regDecode(awAddr_q);
  assign flushNow = doWrite && (wrSel == REG_CTRL) && wStrb_q[0] && wData_q[CTRL_FLUSH_BIT];

  always_comb begin
    awHave_d = awHave_q;
    awAddr_d = awAddr_q;
    wHave_d = wHave_q;
    wData_d = wData_q;
    wStrb_d = wStrb_q;
    bValid_d = bValid_q;
    bResp_d = bResp_q;
    run_d = run_q;
    if (s_axi_awvalid && s_axi_awready) begin
      awHave_d = 1'b1;
      awAddr_d = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      wHave_d = 1'b1;
      wData_d = s_axi_wdata;
      wStrb_d = s_axi_wstrb;
    end
    if (doWrite) begin
      awHave_d = 1'b0;
      wHave_d = 1'b0;
      bValid_d = 1'b1;
      bResp_d = RESP_OKAY;
      case (wrSel)
        REG_CTRL: begin
          if (wStrb_q[0]) run_d = wData_q[CTRL_RUN_BIT];
        end
        REG_STATUS, REG_ADVCOUNT, REG_CHAINOUT, REG_PARAMS, REG_REFUSED: begin
          bResp_d = RESP_OKAY;
        end
        default: bResp_d = RESP_SLVERR;
      endcase
    end
    if (bValid_q && s_axi_bready) bValid_d = 1'b0;
    if (!rst_n) begin
      awHave_d = 1'b0;
      awAddr_d = '0;
      wHave_d = 1'b0;
      wData_d = '0;
      wStrb_d = '0;
      bValid_d = 1'b0;
      bResp_d = RESP_OKAY;
      run_d = CTRL_RUN_RESET;
    end
  end

  always_ff @(posedge mclk) begin
    awHave_q <= awHave_d;
    awAddr_q <= awAddr_d;
    wHave_q <= wHave_d;
    wData_q <= wData_d;
    wStrb_q <= wStrb_d;
    bValid_q <= bValid_d;
    bResp_q <= bResp_d;
    run_q <= run_d;
  end

  assign s_axi_bvalid = bValid_q;
  assign s_axi_bresp = bResp_q;

  // Read channel: one read in flight; data registered on the address handshake
  assign s_axi_arready = !rValid_q;
  assign rdSel = regDecode(s_axi_araddr);

  always_comb begin
    rdWord = '0;
    case (rdSel)
      REG_CTRL: rdWord[CTRL_RUN_BIT] = run_q;
      REG_STATUS: begin
        rdWord[STAT_EMPTY_BIT] = !fifoValid;
        rdWord[STAT_FULL_BIT] = !inReady;
        rdWord[STAT_PRIMED_BIT] = (fill_q == FILL_MAX);
        rdWord[STAT_LEVEL_LSB +: FIFO_PTR_W+1] = fifoLevel;
      end
      REG_ADVCOUNT: rdWord = advCount_q;
      REG_CHAINOUT: rdWord[WORD_W-1:0] = chainOut;
      REG_PARAMS: rdWord = {8'(TAP_SPACING), 8'(TAP_COUNT), 16'(WORD_W)};
      REG_REFUSED: rdWord = refused_q;
      default: rdWord = '0;
    endcase
  end

  always_comb begin
    rValid_d = rValid_q;
    rData_d = rData_q;
    rResp_d = rResp_q;
    if (rValid_q && s_axi_rready) rValid_d = 1'b0;
    if (s_axi_arvalid && s_axi_arready) begin
      rValid_d = 1'b1;
      rData_d = rdWord;
      rResp_d = (rdSel == REG_NONE) ? RESP_SLVERR : RESP_OKAY;
    end
    if (!rst_n) begin
      rValid_d = 1'b0;
      rData_d = '0;
      rResp_d = RESP_OKAY;
    end
  end

  always_ff @(posedge mclk) begin
    rValid_q <= rValid_d;
    rData_q <= rData_d;
    rResp_q <= rResp_d;
  end

  assign s_axi_rvalid = rValid_q;
  assign s_axi_rdata = rData_q;
  assign s_axi_rresp = rResp_q;
endmodule // ram_tapped_delay_line
`default_nettype wire

// ===== rtl/tap_delay_pkg.sv
// Constants, register map and types for the memory-backed tapped delay line.
// Assumes one clock domain and a 32-bit AXI4-Lite register port.
`default_nettype none
package tap_delay_pkg;
  // Build choices, all within the permitted sets
  localparam int WORD_W = 8;
  localparam int TAP_COUNT = 4;
  localparam int TAP_SPACING = 8;
  localparam int PTR_W = 3;
  localparam int TAPS_W = WORD_W * TAP_COUNT;
  localparam bit HAS_ENABLE = 1'b1;
  localparam bit HAS_CLEAR = 1'b1;
  localparam bit HAS_TAP_GROUPS = 1'b1;

  localparam int FIFO_DEPTH = 8;
  localparam int FIFO_PTR_W = 3;

  // Advances since clear, saturating one advance before the last tap holds live data
  localparam int FILL_W = 5;
  localparam logic [FILL_W-1:0] FILL_MAX = FILL_W'(TAP_COUNT * TAP_SPACING - 1);
  localparam logic [FILL_W-1:0] READ_MIN = FILL_W'(TAP_SPACING - 1);
  localparam logic [PTR_W-1:0] PTR_LAST = PTR_W'(TAP_SPACING - 1);
  localparam logic [PTR_W-1:0] PTR_RESET = 3'h0;

  // Register map (byte addresses)
  localparam int ADDR_W = 8;
  localparam logic [ADDR_W-1:0] CTRL_OFFSET = 8'h00;
  localparam logic [ADDR_W-1:0] STATUS_OFFSET = 8'h04;
  localparam logic [ADDR_W-1:0] ADVCOUNT_OFFSET = 8'h08;
  localparam logic [ADDR_W-1:0] CHAINOUT_OFFSET = 8'h0c;
  localparam logic [ADDR_W-1:0] PARAMS_OFFSET = 8'h10;
  localparam logic [ADDR_W-1:0] REFUSED_OFFSET = 8'h14;

  localparam int CTRL_RUN_BIT = 0;
  localparam int CTRL_FLUSH_BIT = 1;
  localparam logic CTRL_RUN_RESET = 1'b1;
  localparam int STAT_EMPTY_BIT = 0;
  localparam int STAT_FULL_BIT = 1;
  localparam int STAT_PRIMED_BIT = 2;
  localparam int STAT_LEVEL_LSB = 8;
  localparam logic [31:0] COUNT_RESET = 32'h0000_0000;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [2:0] {
    REG_CTRL = 3'b000,
    REG_STATUS = 3'b001,
    REG_ADVCOUNT = 3'b010,
    REG_CHAINOUT = 3'b011,
    REG_PARAMS = 3'b100,
    REG_REFUSED = 3'b101,
    REG_NONE = 3'b111
  } regSel_t;
endpackage
`default_nettype wire

// ===== testbench/tap_delay_checker.sv
// Port-level assertions for the tapped delay line.
// Assumes one clock, mclk, and synchronous active-low rst_n.
`timescale 1ns/1ns
`default_nettype none
module tap_delay_checker
  import tap_delay_pkg::*;
(
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic inValid,
  input wire logic inReady,
  input wire logic advanceEnable,
  input wire logic asyncClear,
  input wire logic [tap_delay_pkg::WORD_W-1:0] chainOut,
  input wire logic [tap_delay_pkg::TAPS_W-1:0] tapOut,
  input wire logic [tap_delay_pkg::WORD_W-1:0] tapWord [tap_delay_pkg::TAP_COUNT],
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  import tap_delay_pkg::*;
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);
  AST_CLR_ZERO: assert property (asyncClear |-> chainOut == '0 && tapOut == '0)
    else $error("taps not zero under clear");
  AST_LAST_TAP: assert property (tapOut[TAPS_W-1 -: WORD_W] == chainOut)
    else $error("last tap differs from chain output");
  AST_GROUPS: assert property (tapWord[0] == tapOut[WORD_W-1:0] && tapWord[TAP_COUNT-1] == chainOut)
    else $error("tap group differs from tap bus");
  // Write phases excluded: a flush may legally zero the taps
  AST_HOLD: assert property (!advanceEnable && !asyncClear && s_axi_awready && !s_axi_awvalid
    |=> $stable(tapOut) || asyncClear)
    else $error("taps moved without enable");
  AST_REFILL: assert property ($fell(asyncClear) |-> (tapOut == '0) [*8])
    else $error("stale word after clear");
  AST_BTIME: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
    |-> ##2 s_axi_bvalid)
    else $error("write response late");
  AST_BHOLD: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
  AST_RTIME: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
    else $error("read response late");
  AST_RHOLD: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");
  COV_FULL: cover property (inValid && !inReady);
  COV_CLR: cover property ($rose(asyncClear));
  COV_LIVE: cover property (advanceEnable && chainOut != '0);
endmodule // tap_delay_checker
bind ram_tapped_delay_line tap_delay_checker chk (.*);
`default_nettype wire

// ===== testbench/tb_top.sv
// Self-checking bench: queue model of FIFO and chain, AXI4-Lite master tasks.
// Assumes the design package and the word_source partner model.
`timescale 1ns/1ns
`default_nettype none
`define CHK(n, e, g) begin numChecks++; if ((g) !== (e)) begin errCount++; \
  $display("[ERR] %s exp %h got %h", n, e, g); end end
module tb_top;
  import tap_delay_pkg::*;
  logic mclk = 0, rst_n = 0, advanceEnable = 0, asyncClear = 0, offer = 0;
  logic inValid, inReady, s_axi_awready, s_axi_wready, s_axi_bvalid;
  logic s_axi_arready, s_axi_rvalid;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0;
  logic s_axi_rready = 0;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic [ADDR_W-1:0] s_axi_awaddr = '0, s_axi_araddr = '0;
  logic [31:0] s_axi_wdata = '0, s_axi_rdata, rd;
  logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
  logic [WORD_W-1:0] inWord, chainOut;
  logic [WORD_W-1:0] tapWord [TAP_COUNT];
  logic [TAPS_W-1:0] tapOut, ex;
  int errCount = 0, numChecks = 0, refused = 0, advCnt = 0, fq[$], hist[$];
  integer seed = 32'haa9f;
  bit run = 1, wBusy = 0;
  always #25 mclk = ~mclk;
  ram_tapped_delay_line dut (.*);
  word_source src (.*);
  function automatic logic [TAPS_W-1:0] expTaps();
    expTaps = '0;
    for (int k = 1; k <= TAP_COUNT; k++) begin
      if (hist.size() >= TAP_SPACING * k) begin
        expTaps[(k-1)*WORD_W +: WORD_W] = WORD_W'(hist[hist.size() - TAP_SPACING * k]);
      end
    end
  endfunction
  always @(posedge mclk) begin
    if (!rst_n) begin
      fq.delete();
      hist.delete();
      refused = 0;
      advCnt = 0;
      run = 1;
    end else begin
      if (advanceEnable && run && fq.size() > 0) begin
        hist.push_back(fq.pop_front());
        advCnt++;
        if (hist.size() > 32) void'(hist.pop_front());
      end
      if (inValid && inReady) fq.push_back(inWord);
      else if (inValid) refused++;
    end
  end
  always @(negedge mclk) begin
    if (asyncClear) begin
      hist.delete();
      advCnt = 0;
    end
    if (rst_n && !wBusy) begin
      ex = expTaps();
      `CHK("taps", ex, tapOut)
      `CHK("chain", ex[TAPS_W-1 -: WORD_W], chainOut)
      `CHK("ready", fq.size() < FIFO_DEPTH, inReady)
      for (int k = 0; k < TAP_COUNT; k++) `CHK("tapWord", ex[k*WORD_W +: WORD_W], tapWord[k])
    end
  end
  task automatic axw(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    bit aw, w;
    wBusy = 1;
    @(posedge mclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1;
    s_axi_wvalid <= 1;
    s_axi_bready <= 1;
    aw = 0;
    w = 0;
    while (!(aw && w)) begin
      @(posedge mclk);
      if (!aw && s_axi_awready) begin
        aw = 1;
        s_axi_awvalid <= 0;
      end
      if (!w && s_axi_wready) begin
        w = 1;
        s_axi_wvalid <= 0;
      end
    end
    do @(posedge mclk); while (!s_axi_bvalid);
    s_axi_bready <= 0;
    `CHK("bresp", r, s_axi_bresp)
    if (a == CTRL_OFFSET && r == RESP_OKAY) begin
      run = d[0];
      if (d[1]) begin
        hist.delete();
        advCnt = 0;
      end
    end
    wBusy = 0;
  endtask
  task automatic chk(input logic [7:0] a, input logic [31:0] e, input logic [1:0] r,
    input logic [31:0] m = 32'hffff_ffff);
    @(posedge mclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1;
    s_axi_rready <= 1;
    do @(posedge mclk); while (!s_axi_arready);
    s_axi_arvalid <= 0;
    do @(posedge mclk); while (!s_axi_rvalid);
    s_axi_rready <= 0;
    `CHK("rdata", e, s_axi_rdata & m)
    `CHK("rresp", r, s_axi_rresp)
  endtask
  // Random enable and offer gaps exercise both prompt and slow sources
  task automatic stream(input int n);
    repeat (n) begin
      @(posedge mclk);
      advanceEnable <= 1'($random(seed));
      offer <= 1'($random(seed));
    end
    @(posedge mclk);
    advanceEnable <= 0;
    offer <= 0;
    repeat (2) @(posedge mclk);
  endtask
  task automatic completeRun();
    $display("checks %0d mismatches %0d", numChecks, errCount);
    if (errCount == 0 && numChecks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  initial begin
    #(5000 * 50);
    errCount++;
    $display("watchdog expired");
    completeRun();
  end
  initial begin
    repeat (4) @(posedge mclk);
    rst_n <= 1;
    chk(CTRL_OFFSET, 32'h1, RESP_OKAY);
    chk(PARAMS_OFFSET, 32'h0804_0008, RESP_OKAY);
    axw(PARAMS_OFFSET, 32'h0, RESP_OKAY);
    chk(PARAMS_OFFSET, 32'h0804_0008, RESP_OKAY);
    axw(8'h20, 32'h1, RESP_SLVERR);
    chk(8'h20, 32'h0, RESP_SLVERR);
    $display("test registers done");
    stream(300);
    chk(ADVCOUNT_OFFSET, 32'(advCnt), RESP_OKAY);
    ex = expTaps();
    chk(CHAINOUT_OFFSET, 32'(ex[TAPS_W-1 -: WORD_W]), RESP_OKAY);
    $display("test stream done");
    offer <= 1;
    repeat (12) @(posedge mclk);
    offer <= 0;
    chk(STATUS_OFFSET, 32'h802, RESP_OKAY, 32'hffff_fffb);
    @(posedge mclk);
    advanceEnable <= 1;
    repeat (12) @(posedge mclk);
    advanceEnable <= 0;
    chk(STATUS_OFFSET, 32'h1, RESP_OKAY, 32'hffff_fffb);
    chk(REFUSED_OFFSET, 32'(refused), RESP_OKAY);
    $display("test fifo done");
    offer <= 1;
    advanceEnable <= 1;
    repeat (40) @(posedge mclk);
    advanceEnable <= 0;
    asyncClear <= 1;
    #5;
    `CHK("clear", '0, {chainOut, tapOut})
    repeat (3) @(posedge mclk);
    asyncClear <= 0;
    stream(100);
    $display("test clear done");
    axw(CTRL_OFFSET, 32'h0, RESP_OKAY);
    offer <= 1;
    advanceEnable <= 1;
    repeat (10) @(posedge mclk);
    advanceEnable <= 0;
    axw(CTRL_OFFSET, 32'h3, RESP_OKAY);
    chk(ADVCOUNT_OFFSET, 32'h0, RESP_OKAY);
    stream(60);
    @(posedge mclk);
    rst_n <= 0;
    repeat (2) @(posedge mclk);
    rst_n <= 1;
    chk(REFUSED_OFFSET, 32'h0, RESP_OKAY);
    stream(60);
    $display("test run flush reset done");
    completeRun();
  end
endmodule // tb_top
`default_nettype wire

// ===== testbench/word_source.sv
// Stand-in for the fabric logic that feeds words into the delay line.
// Holds each offered word until taken; scrambles the idle bus.
`timescale 1ns/1ns
`default_nettype none
module word_source
  import tap_delay_pkg::*;
(
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic offer,
  input wire logic inReady,
  output logic inValid,
  output logic [tap_delay_pkg::WORD_W-1:0] inWord
);
  integer seed = 32'haa9f;
  initial begin
    inValid = 1'b0;
    inWord = '0;
  end
  always @(posedge mclk) begin
    if (!rst_n) begin
      inValid <= 1'b0;
    end else if (!inValid || inReady) begin
      inValid <= offer;
      inWord <= offer ? WORD_W'($random(seed)) : ~inWord;
    end
  end
endmodule // word_source
`default_nettype wire
